// ---- rtl/strobe_delay_pkg.sv ----
package strobe_delay_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0]  IDX_DELAY_RATIO   = 8'h35;
    localparam logic [7:0]  IDX_QUARTER_DELAY = 8'h36;
    localparam logic [7:0]  IDX_WRITE_DEBUG   = 8'h37;
    localparam logic [7:0]  IDX_ROUTE_SELECT  = 8'h38;
    localparam int          ADDR_LSB          = 2;
    localparam int          REG_WIDTH         = 16;
    localparam int          TAP_WIDTH         = 9;
    localparam logic [8:0]  TAP_MAX           = 9'h1FF;
    localparam logic [15:0] RATIO_RESET       = 16'h0000;
    localparam logic [15:0] QUARTER_RESET     = 16'h0000;
    localparam logic [15:0] ROUTE_RESET       = 16'h0000;
    localparam logic [15:0] QUARTER_MASK      = 16'h01FF;
    localparam int          WR_SEL_HI         = 15;
    localparam int          WR_SEL_LO         = 8;
    localparam int          RD_SEL_HI         = 7;
    localparam int          RD_SEL_LO         = 0;
    localparam int          SEL_OTHER_BIT     = 7;
    localparam logic [7:0]  SEL_NONE          = 8'h00;
    localparam logic [1:0]  RESP_OKAY         = 2'h0;
    localparam logic [1:0]  RESP_SLVERR       = 2'h2;
endpackage

// ---- rtl/debug_route_mux.sv ----
`timescale 1ns/100ps
// ---------------------------------------------------------------
// debug status routing between self-calibration and other modules
// ---------------------------------------------------------------
module debug_route_mux (
    input  wire logic [7:0]  writeRouteSelect,
    input  wire logic [7:0]  readRouteSelect,
    input  wire logic [15:0] calReadStatus,
    input  wire logic [15:0] otherReadStatus,
    output logic             calWriteEn,
    output logic             otherWriteEn,
    output logic [15:0]      routedReadStatus
);
    import strobe_delay_pkg::*;

    // a zero write select enables nothing; top bit picks the other modules
    always_comb begin
        calWriteEn   = (writeRouteSelect != SEL_NONE) && !writeRouteSelect[SEL_OTHER_BIT];
        otherWriteEn = writeRouteSelect[SEL_OTHER_BIT];
        routedReadStatus = readRouteSelect[SEL_OTHER_BIT] ? otherReadStatus : calReadStatus;
    end
endmodule // debug_route_mux

// ---- rtl/strobe_delay_debug_regs.sv ----
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module strobe_delay_debug_regs (
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // axi4-lite slave
    input  wire logic [9:0]           s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [9:0]           s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    // delay line side
    output logic [8:0]                gateDelayTaps,
    output logic [8:0]                trackDelayTaps,
    output logic [15:0]               delayRatio,
    // debug side
    input  wire logic [15:0]          writeDebugIn,
    input  wire logic [15:0]          calReadStatus,
    input  wire logic [15:0]          otherReadStatus,
    output logic                      calWriteEn,
    output logic                      otherWriteEn,
    output logic [15:0]               routedReadStatus
);
    import strobe_delay_pkg::*;

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    // every flop of the slice lives in this one word; the bus readies are
    // kept as flops too, so no output is a decode of several flops
    typedef struct packed {
        logic        awHeld;
        logic [7:0]  awIdx;
        logic        wHeld;
        logic [15:0] wData;
        logic [1:0]  wStrb;
        logic        bValid;
        logic [1:0]  bResp;
        logic        rValid;
        logic [31:0] rData;
        logic [1:0]  rResp;
        logic        awRdy;
        logic        wRdy;
        logic        arRdy;
        logic [15:0] ratio;
        logic [8:0]  quarter;
        logic [15:0] wrDebug;
        logic [15:0] route;
        logic        calWe;
        logic        otherWe;
        logic [15:0] routedRd;
    } state_s;

    // registered copy and the value it takes at the next edge
    state_s stateReg;
    state_s stateNext;

    // combinational helpers
    logic        muxCalWe;
    logic        muxOtherWe;
    logic [15:0] muxRead;
    logic        awTake;
    logic        wTake;
    logic        doWrite;
    logic        arTake;
    logic [7:0]  arIdx;

    // ---------------------------------------------------------------
    // routing of debug status
    // ---------------------------------------------------------------
    // the decode is registered below, so the enables trail the index by one cycle
    debug_route_mux debug_route_mux_i (
        .writeRouteSelect (stateReg.route[WR_SEL_HI:WR_SEL_LO]),
        .readRouteSelect  (stateReg.route[RD_SEL_HI:RD_SEL_LO]),
        .calReadStatus    (calReadStatus),
        .otherReadStatus  (otherReadStatus),
        .calWriteEn       (muxCalWe),
        .otherWriteEn     (muxOtherWe),
        .routedReadStatus (muxRead)
    );

    // handshakes: one address and one data slot, freed by the response
    assign awTake  = s_axi_awvalid && stateReg.awRdy;
    assign wTake   = s_axi_wvalid && stateReg.wRdy;
    assign doWrite = stateReg.awHeld && stateReg.wHeld && !stateReg.bValid;
    assign arTake  = s_axi_arvalid && stateReg.arRdy;
    assign arIdx   = s_axi_araddr[ADDR_LSB +: 8];

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        stateNext = stateReg;
        // address and data are taken in either order and parked until both are in
        if (awTake) begin
            stateNext.awHeld = 1'b1;
            stateNext.awIdx  = s_axi_awaddr[ADDR_LSB +: 8];
        end
        // only the low two byte lanes reach a sixteen-bit register
        if (wTake) begin
            stateNext.wHeld = 1'b1;
            stateNext.wData = s_axi_wdata[REG_WIDTH-1:0];
            stateNext.wStrb = s_axi_wstrb[1:0];
        end
        // write commit, byte lanes respected, reserved bits dropped
        if (doWrite) begin
            stateNext.awHeld = 1'b0;
            stateNext.wHeld  = 1'b0;
            stateNext.bValid = 1'b1;
            stateNext.bResp  = RESP_OKAY;
            case (stateReg.awIdx)
                // no field meaning is given to the ratio, so all sixteen bits are kept
                IDX_DELAY_RATIO: begin
                    if (stateReg.wStrb[0]) stateNext.ratio[7:0] = stateReg.wData[7:0];
                    if (stateReg.wStrb[1]) stateNext.ratio[15:8] = stateReg.wData[15:8];
                end
                IDX_QUARTER_DELAY: begin
                    // any tap 0..511 accepted; bits 15:9 ignored
                    if (stateReg.wStrb[0]) stateNext.quarter[7:0] = stateReg.wData[7:0];
                    if (stateReg.wStrb[1]) stateNext.quarter[8] = stateReg.wData[8];
                end
                IDX_ROUTE_SELECT: begin
                    if (stateReg.wStrb[0]) stateNext.route[7:0] = stateReg.wData[7:0];
                    if (stateReg.wStrb[1]) stateNext.route[15:8] = stateReg.wData[15:8];
                end
                // read-only word: write accepted, value untouched
                IDX_WRITE_DEBUG: stateNext.bResp = RESP_OKAY;
                default: stateNext.bResp = RESP_SLVERR;
            endcase
        end
        // the response stands until the master takes it
        if (stateReg.bValid && s_axi_bready) begin
            stateNext.bValid = 1'b0;
        end
        // read: answered the cycle after the address is taken
        if (arTake) begin
            stateNext.rValid = 1'b1;
            stateNext.rResp  = RESP_OKAY;
            stateNext.rData  = 32'h00000000;
            case (arIdx)
                IDX_DELAY_RATIO:   stateNext.rData[15:0] = stateReg.ratio;
                IDX_QUARTER_DELAY: stateNext.rData[15:0] = {7'h00, stateReg.quarter};
                IDX_WRITE_DEBUG:   stateNext.rData[15:0] = stateReg.wrDebug;
                IDX_ROUTE_SELECT:  stateNext.rData[15:0] = stateReg.route;
                default:           stateNext.rResp = RESP_SLVERR;
            endcase
        end else if (stateReg.rValid && s_axi_rready) begin
            stateNext.rValid = 1'b0;
        end
        // write path status captured every cycle
        stateNext.wrDebug  = writeDebugIn;
        stateNext.calWe    = muxCalWe;
        stateNext.otherWe  = muxOtherWe;
        stateNext.routedRd = muxRead;
        // readies from flops: a slot reopens the cycle after its response is taken
        stateNext.awRdy    = !stateNext.awHeld && !stateNext.bValid;
        stateNext.wRdy     = !stateNext.wHeld && !stateNext.bValid;
        stateNext.arRdy    = !stateNext.rValid;
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    // one synchronous reset; otherwise the whole word is copied each edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            // readies stay low through reset and rise on the first edge after it
            stateReg <= '0;
            stateReg.ratio   <= RATIO_RESET;
            stateReg.quarter <= QUARTER_RESET[TAP_WIDTH-1:0];
            stateReg.route   <= ROUTE_RESET;
        end else begin
            stateReg <= stateNext;
        end
    end

    // outputs straight from flops; one tap value feeds both uses
    assign s_axi_awready    = stateReg.awRdy;
    assign s_axi_wready     = stateReg.wRdy;
    assign s_axi_bvalid     = stateReg.bValid;
    assign s_axi_bresp      = stateReg.bResp;
    assign s_axi_arready    = stateReg.arRdy;
    assign s_axi_rvalid     = stateReg.rValid;
    assign s_axi_rdata      = stateReg.rData;
    assign s_axi_rresp      = stateReg.rResp;
    assign gateDelayTaps    = stateReg.quarter;
    assign trackDelayTaps   = stateReg.quarter;
    assign delayRatio       = stateReg.ratio;
    assign calWriteEn       = stateReg.calWe;
    assign otherWriteEn     = stateReg.otherWe;
    assign routedReadStatus = stateReg.routedRd;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    // every check samples on the system clock and sleeps through reset, so a
    // reset in mid-run cannot trip a $past or $stable comparison
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // full-strobe quarter write: taps load on the next edge
    sequence qtrWrite_s;
        doWrite && stateReg.awIdx == IDX_QUARTER_DELAY && stateReg.wStrb == 2'h3;
    endsequence

    // low-lane-only quarter write: tap bit 8 must stay put
    sequence qtrLowWrite_s;
        doWrite && stateReg.awIdx == IDX_QUARTER_DELAY && stateReg.wStrb == 2'h1;
    endsequence

    sequence trackLoaded_s;
        trackDelayTaps == $past(stateReg.wData[TAP_WIDTH-1:0]);
    endsequence

    // read-only word: a read returns the captured status and a write to it
    // leaves every writable register as it was
    sequence dbgRead_s;
        arTake && arIdx == IDX_WRITE_DEBUG;
    endsequence

    sequence dbgWrite_s;
        doWrite && stateReg.awIdx == IDX_WRITE_DEBUG;
    endsequence

    // full-strobe write of the debug index
    sequence routeWrite_s;
        doWrite && stateReg.awIdx == IDX_ROUTE_SELECT && stateReg.wStrb == 2'h3;
    endsequence

    // a write to a word outside the slice
    sequence badWrite_s;
        doWrite && !(stateReg.awIdx inside {[IDX_DELAY_RATIO:IDX_ROUTE_SELECT]});
    endsequence

    // tap count: loaded by a write, shared by both users, held otherwise
    tap_load_a: assert property (qtrWrite_s |=> gateDelayTaps == $past(stateReg.wData[8:0]))
        else $error("quarter delay taps not loaded");
    tap_track_a: assert property (qtrWrite_s |=> trackLoaded_s)
        else $error("tracking taps not loaded");
    tap_low_a: assert property (
        qtrLowWrite_s |=> gateDelayTaps[TAP_WIDTH-1] == $past(gateDelayTaps[TAP_WIDTH-1]))
        else $error("tap bit 8 moved on a low lane write");
    tap_hold_a: assert property (!doWrite |=> $stable(gateDelayTaps))
        else $error("taps changed without a write");
    dbg_ro_a: assert property (
        dbgRead_s |=> s_axi_rdata[REG_WIDTH-1:0] == $past(stateReg.wrDebug))
        else $error("write debug word not read back");
    dbg_keep_a: assert property (
        dbgWrite_s |=> $stable(gateDelayTaps) && $stable(delayRatio) && $stable(stateReg.route))
        else $error("write to read-only word changed a register");

    // routing: enables and read word trail the index by one flop
    route_load_a: assert property (
        routeWrite_s |=> stateReg.route == $past(stateReg.wData))
        else $error("debug index not loaded");
    wr_none_a: assert property (stateReg.route[15:8] == SEL_NONE |=> !calWriteEn && !otherWriteEn)
        else $error("debug write with zero select");
    wr_cal_a: assert property (
        stateReg.route[WR_SEL_HI:WR_SEL_LO] inside {[8'h01:8'h7F]} |=> calWriteEn && !otherWriteEn)
        else $error("low write select not routed to self calibration");
    wr_route_a: assert property (stateReg.route[15] |=> otherWriteEn && !calWriteEn)
        else $error("high write select not routed to others");
    rd_cal_a: assert property (!stateReg.route[7] |=> routedReadStatus == $past(calReadStatus))
        else $error("read not routed from self calibration");
    rd_other_a: assert property (stateReg.route[7] |=> routedReadStatus == $past(otherReadStatus))
        else $error("read not routed from other modules");
    rsv_zero_a: assert property (
        arTake && arIdx == IDX_QUARTER_DELAY |=> s_axi_rdata[15:9] == 7'h00)
        else $error("reserved bits read nonzero");

    // ---------------------------------------------------------------
    // register bus answers
    // ---------------------------------------------------------------
    // a committed write answers next cycle and blocks new write address and data until bready; reads stay open
    wr_answer_a: assert property (
        doWrite |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response missing");
    rd_answer_a: assert property (arTake |=> s_axi_rvalid && !s_axi_arready)
        else $error("read response missing");
    rd_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("read data above the register width");
    bad_write_a: assert property (badWrite_s |=> s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
endmodule // strobe_delay_debug_regs

// ---- testbench/debug_source_model.sv ----
`timescale 1ns/100ps
// ---------------------------------------------------------------
// debug status sources on the far side of the register slice
// ---------------------------------------------------------------
module debug_source_model #(
    parameter logic [15:0] CAL_STATUS   = 16'h3C5A,
    parameter logic [15:0] OTHER_STATUS = 16'hA5C3,
    parameter logic [15:0] WRITE_STATUS = 16'h5AA5
) (
    input  wire logic        calWriteEn,
    input  wire logic        otherWriteEn,
    output logic [15:0]      calReadStatus,
    output logic [15:0]      otherReadStatus,
    output logic [15:0]      writeDebugIn
);
    // write status is offered only while a write target is selected,
    // so a missing enable shows up as a zero word
    always_comb begin
        calReadStatus   = CAL_STATUS;
        otherReadStatus = OTHER_STATUS;
        writeDebugIn    = (calWriteEn | otherWriteEn) ? WRITE_STATUS : 16'h0000;
    end
endmodule // debug_source_model

// ---- testbench/strobe_delay_debug_regs_tb.sv ----
`timescale 1ns/100ps
module strobe_delay_debug_regs_tb;
    import strobe_delay_pkg::*;
    localparam logic [15:0] CAL_ST = 16'h3C5A, OTH_ST = 16'hA5C3, WR_ST = 16'h5AA5;
    logic sys_clk = 0, rst = 1;
    logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, calWriteEn, otherWriteEn;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = '0;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [8:0] gateDelayTaps, trackDelayTaps;
    logic [15:0] delayRatio, writeDebugIn, calReadStatus, otherReadStatus, routedReadStatus;
    logic [31:0] rd;
    logic [15:0] routes [5] = '{16'h0000, 16'h0180, 16'h7F7F, 16'h80FF, 16'hFF00};
    int num_errors = 0, checks_done = 0;
    strobe_delay_debug_regs strobe_delay_debug_regs_i (.sys_clk, .rst, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .gateDelayTaps, .trackDelayTaps, .delayRatio, .writeDebugIn,
        .calReadStatus, .otherReadStatus, .calWriteEn, .otherWriteEn, .routedReadStatus);
    debug_source_model #(.CAL_STATUS(CAL_ST), .OTHER_STATUS(OTH_ST), .WRITE_STATUS(WR_ST))
        debug_source_model_i (.calWriteEn, .otherWriteEn, .calReadStatus,
        .otherReadStatus, .writeDebugIn);
    // 125 MHz system clock
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic finish_test();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // each channel is dropped at the edge where it is taken; bready stays up until bvalid
    task automatic axi_write(input logic [7:0] idx, input logic [15:0] d,
                             input logic [3:0] strb, output logic [1:0] rsp);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1 && n < 200);
        if (n >= 200) begin
            num_errors++;
            finish_test();
        end
        rsp = s_axi_bresp;
        s_axi_bready <= 0;
    endtask
    task automatic axi_read(input logic [7:0] idx, output logic [31:0] dat,
                            output logic [1:0] rsp);
        int n;
        n = 0;
        @(posedge sys_clk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1 && n < 200);
        if (n >= 200) begin
            num_errors++;
            finish_test();
        end
        dat = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 0;
    endtask
    // read a register and compare data and response
    task automatic read_check(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
        axi_read(idx, rd, resp);
        check(rd, exp);
        check({30'h0, resp}, {30'h0, er});
    endtask
    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 0;
        read_check(IDX_DELAY_RATIO, 32'h0, RESP_OKAY);
        read_check(IDX_QUARTER_DELAY, 32'h0, RESP_OKAY);
        read_check(IDX_WRITE_DEBUG, 32'h0, RESP_OKAY);
        read_check(IDX_ROUTE_SELECT, 32'h0, RESP_OKAY);
        // all ones: only the nine tap bits may stick
        axi_write(IDX_QUARTER_DELAY, 16'hFFFF, 4'hF, resp);
        read_check(IDX_QUARTER_DELAY, 32'h1FF, RESP_OKAY);
        check({23'h0, gateDelayTaps}, 32'h1FF);
        check({23'h0, trackDelayTaps}, 32'h1FF);
        axi_write(IDX_QUARTER_DELAY, 16'h0000, 4'h1, resp);
        read_check(IDX_QUARTER_DELAY, 32'h100, RESP_OKAY);
        axi_write(IDX_DELAY_RATIO, 16'hA5C3, 4'h3, resp);
        read_check(IDX_DELAY_RATIO, 32'hA5C3, RESP_OKAY);
        check({16'h0, delayRatio}, 32'hA5C3);
        // reset in mid-run: the taps and the ratio return to zero
        rst <= 1;
        repeat (3) @(posedge sys_clk);
        rst <= 0;
        read_check(IDX_QUARTER_DELAY, 32'h0, RESP_OKAY);
        check({23'h0, trackDelayTaps}, 32'h0);
        check({16'h0, delayRatio}, 32'h0);
        // every write target class and both read sources
        foreach (routes[k]) begin
            axi_write(IDX_ROUTE_SELECT, routes[k], 4'h3, resp);
            repeat (2) @(posedge sys_clk);
            #1;
            check({31'h0, calWriteEn}, {31'h0, routes[k][15:8] != 0 && !routes[k][15]});
            check({31'h0, otherWriteEn}, {31'h0, routes[k][15]});
            check({16'h0, routedReadStatus}, {16'h0, routes[k][7] ? OTH_ST : CAL_ST});
            read_check(IDX_ROUTE_SELECT, {16'h0, routes[k]}, RESP_OKAY);
        end
        read_check(IDX_WRITE_DEBUG, {16'h0, WR_ST}, RESP_OKAY);
        axi_write(IDX_WRITE_DEBUG, 16'h1234, 4'h3, resp);
        check({30'h0, resp}, {30'h0, RESP_OKAY});
        read_check(IDX_WRITE_DEBUG, {16'h0, WR_ST}, RESP_OKAY);
        // unmapped word on both channels
        axi_write(8'h3C, 16'hFFFF, 4'hF, resp);
        check({30'h0, resp}, {30'h0, RESP_SLVERR});
        read_check(8'h3C, 32'h0, RESP_SLVERR);
        finish_test();
    end
endmodule // strobe_delay_debug_regs_tb
